// >>> common/valve_tune_pkg.sv
package valve_tune_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // refresh period is one-third of a second
  localparam int unsigned REFRESH_DIV = 3;
  localparam int unsigned REFRESH_CYCLES = CLK_HZ / REFRESH_DIV;
  localparam int SEGS = 10;
  localparam int HALF = 5;
  // wishbone byte addresses
  localparam logic [7:0] ADR_VALVE_POS = 8'h00;
  localparam logic [7:0] ADR_BASE = 8'h04;
  localparam logic [7:0] ADR_START = 8'h08;
  localparam logic [7:0] ADR_PRESET = 8'h0C;
  localparam logic [7:0] ADR_INTEGRAL = 8'h10;
  localparam logic [7:0] ADR_STATUS = 8'h14;
  localparam logic [7:0] ADR_DRIVE = 8'h18;
  localparam int STAT_REJECT = 16;
  // valve values in tenths of a percent of full open
  localparam logic [10:0] POS_MAX = 11'h406;
  localparam logic [10:0] FULL_OPEN = 11'h3E8;
  localparam logic [10:0] FULL_CLOSE = 11'h000;
  localparam logic [10:0] BASE_RST = 11'h000;
  localparam logic [10:0] START_RST = 11'h000;
  localparam logic [10:0] PRESET_RST = 11'h3E6;
  // integral time in hundredths of a second
  localparam logic [13:0] INTEG_MIN = 14'h0002;
  localparam logic [13:0] INTEG_MAX = 14'h2710;
  localparam logic [13:0] INTEG_RST = 14'h001E;
  // ratio thresholds in thousandths, element 0 nearest set point
  localparam logic [11:0] RATIO_ONE = 12'h3E8;
  localparam logic [4:0][11:0] UPPER_TH = {12'h79E, 12'h4B0, 12'h41A, 12'h3F2, 12'h3EA};
  localparam logic [4:0][11:0] LOWER_TH = {12'h032, 12'h320, 12'h3B6, 12'h3DE, 12'h3E6};
  typedef enum logic [2:0] {CM_CLOSE, CM_OPEN, CM_MANUAL, CM_HOLD, CM_AUTO} control_mode_e;
endpackage : valve_tune_pkg

// >>> logic/deviation_bargraph_valve_tuning.sv
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module deviation_bargraph_valve_tuning
  import valve_tune_pkg::*;
#(
  parameter int PW = 24,
  parameter int unsigned P_REFRESH_CYCLES = REFRESH_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  input wire control_mode_e i_mode,
  input wire logic i_soft_active,
  input wire logic [10:0] i_soft_drive,
  input wire logic i_pid_valid,
  input wire logic [10:0] i_pid_drive,
  input wire logic i_sample_valid,
  input wire logic signed [PW-1:0] i_pressure,
  input wire logic signed [PW-1:0] i_set_point,
  output logic [SEGS-1:0] o_segments,
  output logic o_refresh,
  output logic [10:0] o_valve_drive,
  output logic [13:0] o_integral
);

  localparam int W2 = PW + 14;
  localparam logic [31:0] RELOAD = 32'(P_REFRESH_CYCLES - 1);

  typedef struct packed {
    logic [31:0] cnt;
    logic [SEGS-1:0] acc;
    logic [SEGS-1:0] seg;
    logic refresh;
    logic [10:0] pos;
    logic [10:0] drive;
    logic [10:0] out;
    logic [10:0] base;
    logic [10:0] start;
    logic [10:0] preset;
    logic [13:0] integ;
    control_mode_e prev;
    logic reject;
    logic ack;
    logic [31:0] rdat;
  } state_s;

  localparam state_s ST_RST = '{base: BASE_RST, start: START_RST, preset: PRESET_RST,
                                integ: INTEG_RST, prev: CM_CLOSE, default: '0};

  state_s s;
  state_s n;

  ////////////////////////////////////////////////////////////////////////////////
  // deviation bands; comparing scaled products avoids a divider
  logic signed [W2-1:0] p_ext;
  logic signed [W2-1:0] sp_ext;
  logic signed [W2-1:0] pn;
  logic signed [W2-1:0] dn;
  logic signed [W2-1:0] scaled_p;
  logic [HALF-1:0] up_ge;
  logic [HALF-1:0] lo_lt;
  logic [SEGS-1:0] band_hit;
  logic [SEGS-1:0] sample_hit;

  assign p_ext = W2'(i_pressure);
  assign sp_ext = W2'(i_set_point);
  // a negative set point flips both signs so the ratio is unchanged
  assign pn = (i_set_point < 0) ? -p_ext : p_ext;
  assign dn = (i_set_point < 0) ? -sp_ext : sp_ext;
  assign scaled_p = pn * $signed({1'b0, RATIO_ONE});

  for (genvar i = 0; i < HALF; i++) begin : g_band
    assign up_ge[i] = scaled_p >= dn * $signed({1'b0, UPPER_TH[i]});
    assign lo_lt[i] = scaled_p < dn * $signed({1'b0, LOWER_TH[i]});
    if (i == HALF - 1) begin : g_end
      assign band_hit[HALF+i] = up_ge[i];
      assign band_hit[HALF-1-i] = lo_lt[i];
    end else begin : g_mid
      assign band_hit[HALF+i] = up_ge[i] & ~up_ge[i+1];
      assign band_hit[HALF-1-i] = lo_lt[i] & ~lo_lt[i+1];
    end
  end

  // between the innermost thresholds no band matches at all
  always_comb begin
    if (i_set_point == 0) begin
      if (i_pressure > 0) sample_hit = {1'b1, {(SEGS-1){1'b0}}};
      else if (i_pressure < 0) sample_hit = {{(SEGS-1){1'b0}}, 1'b1};
      else sample_hit = '0;
    end else begin
      sample_hit = band_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state update
  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
    wmerge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : wmerge

  logic tick;
  logic auto_on;
  logic req;
  logic wr;
  logic hold_like;
  logic [15:0] wv;
  logic [15:0] wv_pos;

  assign tick = (s.cnt == 32'h0000_0000);
  assign auto_on = (i_mode == CM_AUTO);
  assign req = i_wb_cyc & i_wb_stb;
  assign wr = req & s.ack & i_wb_we;
  assign hold_like = (i_mode == CM_MANUAL) || (i_mode == CM_HOLD);

  always_comb begin
    n = s;
    wv = '0;
    wv_pos = wmerge({5'h00, s.pos}, i_wb_dat, i_wb_sel);
    n.refresh = 1'b0;
    n.cnt = tick ? RELOAD : s.cnt - 32'h0000_0001;

    // bargraph accumulation and refresh
    if (tick) begin
      n.seg = s.acc;
      n.acc = (i_sample_valid && auto_on) ? sample_hit : '0;
      n.refresh = 1'b1;
    end else if (i_sample_valid && auto_on) begin
      n.acc = s.acc | sample_hit;
    end
    if (!auto_on) begin
      n.seg = '0;
      n.acc = '0;
    end

    // wishbone classic: ack one cycle after the request, dropped the next
    n.ack = req & ~s.ack;
    if (req && !s.ack) begin
      case (i_wb_adr)
        ADR_VALVE_POS: n.rdat = {21'h000000, s.pos};
        ADR_BASE: n.rdat = {21'h000000, s.base};
        ADR_START: n.rdat = {21'h000000, s.start};
        ADR_PRESET: n.rdat = {21'h000000, s.preset};
        ADR_INTEGRAL: n.rdat = {18'h00000, s.integ};
        ADR_STATUS: n.rdat = {15'h0000, s.reject, 6'h00, s.seg};
        ADR_DRIVE: n.rdat = {21'h000000, s.out};
        default: n.rdat = 32'h0000_0000;
      endcase
    end

    // writes take effect at the edge where the master sees ack
    if (wr) begin
      case (i_wb_adr)
        ADR_VALVE_POS: begin
          if (hold_like && wv_pos <= {5'h00, POS_MAX}) begin
            n.pos = wv_pos[10:0];
            n.drive = wv_pos[10:0];
          end else begin
            n.reject = 1'b1;
          end
        end
        ADR_BASE: begin
          wv = wmerge({5'h00, s.base}, i_wb_dat, i_wb_sel);
          if (wv <= {5'h00, POS_MAX}) n.base = wv[10:0];
          else n.reject = 1'b1;
        end
        ADR_START: begin
          wv = wmerge({5'h00, s.start}, i_wb_dat, i_wb_sel);
          if (wv <= {5'h00, POS_MAX}) n.start = wv[10:0];
          else n.reject = 1'b1;
        end
        ADR_PRESET: begin
          wv = wmerge({5'h00, s.preset}, i_wb_dat, i_wb_sel);
          if (wv <= {5'h00, POS_MAX}) n.preset = wv[10:0];
          else n.reject = 1'b1;
        end
        ADR_INTEGRAL: begin
          wv = wmerge({2'h0, s.integ}, i_wb_dat, i_wb_sel);
          if (wv >= {2'h0, INTEG_MIN} && wv <= {2'h0, INTEG_MAX}) n.integ = wv[13:0];
          else n.reject = 1'b1;
        end
        ADR_STATUS: begin
          if (i_wb_sel[2] && i_wb_dat[STAT_REJECT]) n.reject = 1'b0;
        end
        default: n.reject = s.reject;
      endcase
    end

    // control mode transitions; entry actions win over a same-cycle write
    n.prev = i_mode;
    case (i_mode)
      CM_AUTO: begin
        if (i_soft_active) begin
          n.drive = i_soft_drive;
        end else if (s.prev != CM_AUTO) begin
          if (s.prev == CM_OPEN || s.prev == CM_CLOSE) n.drive = s.start;
        end else if (i_pid_valid) begin
          n.drive = i_pid_drive;
        end
      end
      CM_MANUAL: begin
        if (s.prev != CM_MANUAL) begin
          n.drive = s.preset;
          n.pos = s.preset;
        end
      end
      CM_HOLD: begin
        // hold freezes the present drive; only a position write moves it
        if (s.prev != CM_HOLD && s.prev != CM_MANUAL) n.pos = s.drive;
      end
      CM_OPEN: n.drive = FULL_OPEN;
      CM_CLOSE: n.drive = FULL_CLOSE;
      default: n.drive = s.drive;
    endcase
    // floor applied last so it beats the soft-start ramp too
    n.out = (n.drive < n.base) ? n.base : n.drive;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  assign o_wb_ack = s.ack;
  assign o_wb_dat = s.rdat;
  assign o_segments = s.seg;
  assign o_refresh = s.refresh;
  assign o_valve_drive = s.out;
  assign o_integral = s.integ;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  seg_dark_a: assert property (i_mode != CM_AUTO |=> o_segments == '0)
    else $error("segments lit outside automatic control");
  seg_steady_a: assert property ($changed(o_segments) |-> $past(tick) || $past(!auto_on))
    else $error("segments changed between refreshes");
  refresh_gap_a: assert property (o_refresh |=> !o_refresh)
    else $error("refresh pulse too long");
  drive_floor_a: assert property (o_valve_drive >= s.base)
    else $error("valve drive below base");
  ranges_a: assert property (s.base <= POS_MAX && s.start <= POS_MAX && s.preset <= POS_MAX)
    else $error("valve parameter out of range");
  integ_range_a: assert property (o_integral >= INTEG_MIN && o_integral <= INTEG_MAX)
    else $error("integral out of range");
  pos_reject_a: assert property (wr && i_wb_adr == ADR_VALVE_POS && !hold_like
                                 |=> $stable(s.pos) && s.reject)
    else $error("position write accepted outside manual or hold");
  pos_apply_a: assert property (wr && i_wb_adr == ADR_VALVE_POS && i_mode == CM_HOLD
                                && $stable(i_mode) && wv_pos <= {5'h00, POS_MAX}
                                |=> s.drive == $past(wv_pos[10:0]))
    else $error("new position not applied at once");
  manual_entry_a: assert property (i_mode == CM_MANUAL && s.prev != CM_MANUAL
                                   |=> s.drive == $past(s.preset))
    else $error("manual entry did not use preset");
  start_entry_a: assert property (auto_on && !i_soft_active && s.prev == CM_CLOSE
                                  |=> s.drive == $past(s.start))
    else $error("auto entry from close did not use start");
  zero_sp_a: assert property (i_sample_valid && auto_on && i_set_point == 0 && i_pressure > 0
                              |=> s.acc[SEGS-1] && s.acc[SEGS-2:0] == $past(s.acc[SEGS-2:0])
                                  || $past(tick))
    else $error("zero set point did not light only the top segment");
  dead_band_a: assert property (i_sample_valid && auto_on && i_set_point > 0
                                && i_pressure == i_set_point && !tick
                                |=> s.acc == $past(s.acc))
    else $error("segment lit at set point");

  ////////////////////////////////////////////////////////////////////////////////
  // bus answer, refresh timing, accumulation, entry actions and rejection
  // the bench reaches bus answers and refreshes many times, but never drives start or preset rejection

  ack_answer_a: assert property (req && !o_wb_ack |=> o_wb_ack)
    else $error("request not answered in the next cycle");

  refresh_reload_a: assert property (o_refresh |-> s.cnt == RELOAD)
    else $error("refresh pulse without counter reload");

  refresh_due_a: assert property (tick |=> o_refresh)
    else $error("refresh pulse missing at tick");

  seg_copy_a: assert property (tick && auto_on |=> o_segments == $past(s.acc))
    else $error("segments not copied from accumulator");

  acc_restart_a: assert property (tick && auto_on && !i_sample_valid |=> s.acc == '0)
    else $error("accumulator not cleared at refresh");

  acc_keep_a: assert property (!tick && auto_on |=> (s.acc & $past(s.acc)) == $past(s.acc))
    else $error("accumulated segment lost within a period");

  acc_dark_a: assert property (!auto_on |=> s.acc == '0)
    else $error("accumulator kept outside automatic control");

  bottom_zero_a: assert property (i_sample_valid && auto_on && i_set_point == 0
                                  && i_pressure < 0 |=> s.acc[0])
    else $error("zero set point did not light the bottom segment");

  upper_lit_a: assert property (i_sample_valid && auto_on && i_set_point > 0
                                && i_pressure >= i_set_point * 2 |=> s.acc[SEGS-1])
    else $error("large excess did not light the top segment");

  lower_lit_a: assert property (i_sample_valid && auto_on && i_set_point > 0
                                && i_pressure < 0 |=> s.acc[0])
    else $error("negative ratio did not light the bottom segment");

  soft_entry_a: assert property (auto_on && i_soft_active |=> s.drive == $past(i_soft_drive))
    else $error("soft-start ramp not followed");

  open_entry_a: assert property (i_mode == CM_OPEN |=> s.drive == FULL_OPEN)
    else $error("open mode did not drive full open");

  close_entry_a: assert property (i_mode == CM_CLOSE |=> s.drive == FULL_CLOSE)
    else $error("close mode did not drive full close");

  open_start_a: assert property (auto_on && !i_soft_active && s.prev == CM_OPEN
                                 |=> s.drive == $past(s.start))
    else $error("auto entry from open did not use start");

  hold_start_a: assert property (auto_on && !i_soft_active && s.prev == CM_HOLD
                                 |=> $stable(s.drive))
    else $error("auto entry from hold moved the valve");

  hold_freeze_a: assert property (i_mode == CM_HOLD && s.prev == CM_HOLD
                                  && !(wr && i_wb_adr == ADR_VALVE_POS) |=> $stable(s.drive))
    else $error("held drive moved without a position write");

  floor_pick_a: assert property (o_valve_drive == s.drive || o_valve_drive == s.base)
    else $error("valve drive is neither demand nor floor");

  base_reject_a: assert property (wr && i_wb_adr == ADR_BASE && i_wb_sel[1:0] == 2'b11
                                  && i_wb_dat[15:0] > {5'h00, POS_MAX}
                                  |=> $stable(s.base) && s.reject)
    else $error("out of range base accepted");

  start_reject_a: assert property (wr && i_wb_adr == ADR_START && i_wb_sel[1:0] == 2'b11
                                   && i_wb_dat[15:0] > {5'h00, POS_MAX}
                                   |=> $stable(s.start) && s.reject)
    else $error("out of range start accepted");

  preset_reject_a: assert property (wr && i_wb_adr == ADR_PRESET && i_wb_sel[1:0] == 2'b11
                                    && i_wb_dat[15:0] > {5'h00, POS_MAX}
                                    |=> $stable(s.preset) && s.reject)
    else $error("out of range preset accepted");

  integ_reject_a: assert property (wr && i_wb_adr == ADR_INTEGRAL && i_wb_sel[1:0] == 2'b11
                                   && i_wb_dat[15:0] < {2'h0, INTEG_MIN}
                                   |=> $stable(s.integ) && s.reject)
    else $error("too small integral accepted");

  pos_accept_a: assert property (wr && i_wb_adr == ADR_VALVE_POS && i_mode == CM_MANUAL
                                 && s.prev == CM_MANUAL && i_wb_sel[1:0] == 2'b11
                                 && i_wb_dat[15:0] <= {5'h00, POS_MAX}
                                 |=> s.pos == $past(i_wb_dat[10:0]))
    else $error("valid position write in manual not taken");

  reject_stick_a: assert property (s.reject && !(wr && i_wb_adr == ADR_STATUS) |=> s.reject)
    else $error("reject flag lost without a clear");
endmodule : deviation_bargraph_valve_tuning
`default_nettype wire

// >>> sim/valve_model.sv
`timescale 1ns/1ps
`default_nettype none
// valve stem tracks the drive one clock late; no slew, so drive checks stay exact
module valve_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [10:0] i_drive,
  output logic [10:0] o_position
);
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_position <= 11'h000;
    end else begin
      o_position <= i_drive;
    end
  end
endmodule : valve_model
`default_nettype wire

// >>> sim/deviation_bargraph_valve_tuning_tb.sv
`timescale 1ns/1ps
`default_nettype none
module deviation_bargraph_valve_tuning_tb;
  import valve_tune_pkg::*;
  localparam int RC = 50;
  localparam logic signed [23:0] K = 24'sh3E8;
  localparam logic signed [23:0] Z = 24'sh0;
  logic clk, rst, cyc, stb, we, ack, pv, sv, sa, rfr;
  logic [7:0] adr;
  logic [31:0] dat, rdat, q;
  logic [3:0] sel;
  control_mode_e mode;
  logic [10:0] sd, pd, drv, vpos;
  logic signed [23:0] pr, sp;
  logic [9:0] seg;
  logic [13:0] integ;
  int n_errors = 0;
  int samples_checked = 0;
  deviation_bargraph_valve_tuning #(.PW(24), .P_REFRESH_CYCLES(RC))
      deviation_bargraph_valve_tuning_inst (
    .i_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(sel), .o_wb_ack(ack), .o_wb_dat(rdat),
    .i_mode(mode), .i_soft_active(sa), .i_soft_drive(sd), .i_pid_valid(pv),
    .i_pid_drive(pd), .i_sample_valid(sv), .i_pressure(pr), .i_set_point(sp),
    .o_segments(seg), .o_refresh(rfr), .o_valve_drive(drv), .o_integral(integ));
  valve_model valve_model_inst (.i_clk(clk), .i_reset(rst), .i_drive(drv), .o_position(vpos));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  // one classic cycle; ack and read data are taken at the same edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) n_errors++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task automatic drv_is(input logic [10:0] e);
    repeat (2) @(posedge clk);
    #1;
    chk(drv, e);
  endtask : drv_is
  task automatic setm(input control_mode_e m, input logic [10:0] e);
    @(posedge clk);
    mode <= m;
    @(posedge clk);
    #1;
    chk(drv, e);
    @(posedge clk);
    #1;
    chk(vpos, e);
  endtask : setm
  task automatic pid(input logic [10:0] d, input logic [10:0] e);
    @(posedge clk);
    pv <= 1'b1;
    pd <= d;
    @(posedge clk);
    pv <= 1'b0;
    drv_is(e);
  endtask : pid
  // two samples inside one refresh period, then compare at the next tick
  task automatic bar(input logic signed [23:0] s, input logic signed [23:0] p1,
                     input logic signed [23:0] p2, input logic [9:0] e);
    int n;
    n = 0;
    @(posedge clk);
    sp <= s;
    pr <= p1;
    sv <= 1'b1;
    @(posedge clk);
    pr <= p2;
    @(posedge clk);
    sv <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (rfr !== 1'b1 && n < 2 * RC);
    chk(seg, e);
  endtask : bar
  // spacing of two refresh pulses in clock cycles
  task automatic per;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
    end while (rfr !== 1'b1);
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (rfr !== 1'b1 && n < 2 * RC);
    chk(32'(n), 32'(RC));
  endtask : per
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end
  initial begin
    {rst, cyc, stb, we, pv, sv, sa} = 7'h40;
    {adr, dat, sd, pd, pr, sp} = '0;
    sel = 4'hF;
    mode = CM_CLOSE;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(ADR_BASE, 32'h0);
    rd(ADR_START, 32'h0);
    rd(ADR_PRESET, 32'h3E6);
    rd(ADR_INTEGRAL, 32'h1E);
    chk(integ, 32'h1E);
    wb(1'b1, ADR_VALVE_POS, 32'h1F4);
    rd(ADR_STATUS, 32'h10000);
    chk(drv, 32'h0);
    wb(1'b1, ADR_STATUS, 32'h10000);
    rd(ADR_STATUS, 32'h0);
    wb(1'b1, ADR_BASE, 32'h407);
    rd(ADR_BASE, 32'h0);
    wb(1'b1, ADR_BASE, 32'h406);
    rd(ADR_BASE, 32'h406);
    chk(drv, 32'h406);
    wb(1'b1, ADR_BASE, 32'hC8);
    drv_is(11'h0C8);
    wb(1'b1, ADR_INTEGRAL, 32'h1);
    wb(1'b1, ADR_INTEGRAL, 32'h2711);
    rd(ADR_INTEGRAL, 32'h1E);
    wb(1'b1, ADR_INTEGRAL, 32'h2710);
    rd(ADR_INTEGRAL, 32'h2710);
    chk(integ, 32'h2710);
    wb(1'b1, ADR_INTEGRAL, 32'h2);
    rd(ADR_INTEGRAL, 32'h2);
    setm(CM_MANUAL, 11'h3E6);
    wb(1'b1, ADR_VALVE_POS, 32'h1F4);
    drv_is(11'h1F4);
    wb(1'b1, ADR_VALVE_POS, 32'h64);
    drv_is(11'h0C8);
    setm(CM_HOLD, 11'h0C8);
    wb(1'b1, ADR_VALVE_POS, 32'h12C);
    drv_is(11'h12C);
    setm(CM_AUTO, 11'h12C);
    pid(11'h258, 11'h258);
    pid(11'h032, 11'h0C8);
    wb(1'b1, ADR_START, 32'h190);
    rd(ADR_START, 32'h190);
    setm(CM_OPEN, 11'h3E8);
    setm(CM_AUTO, 11'h190);
    setm(CM_CLOSE, 11'h0C8);
    @(posedge clk);
    sa <= 1'b1;
    sd <= 11'h15E;
    setm(CM_AUTO, 11'h15E);
    @(posedge clk);
    sd <= 11'h064;
    drv_is(11'h0C8);
    sa <= 1'b0;
    bar(K, K, 24'sh3E9, 10'h000);
    bar(K, 24'sh3EA, 24'sh3DE, 10'h030);
    bar(K, 24'sh3F2, 24'sh3B6, 10'h048);
    bar(K, 24'sh41A, 24'sh320, 10'h084);
    bar(K, 24'sh4B0, 24'sh032, 10'h102);
    bar(K, 24'sh79E, 24'sh031, 10'h201);
    bar(K, K, 24'sh3E6, 10'h000);
    bar(Z, 24'sh5, Z, 10'h200);
    bar(Z, -24'sh5, Z, 10'h001);
    bar(Z, Z, Z, 10'h000);
    bar(K, 24'sh79E, 24'sh79E, 10'h200);
    per();
    setm(CM_MANUAL, 11'h3E6);
    chk(seg, 32'h0);
    bar(K, 24'sh79E, 24'sh79E, 10'h000);
    summarize();
  end
endmodule : deviation_bargraph_valve_tuning_tb
`default_nettype wire
